// *** hdl/rssr_pkg.sv ***
package rssr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] RSSR_OFS_SEC_STATUS = 12'h02C;
  localparam logic [11:0] RSSR_OFS_CHANNEL = 12'h02E;
  localparam logic [11:0] RSSR_OFS_XTAL_TRIM = 12'h02F;
  localparam logic [11:0] RSSR_OFS_TX_POWER = 12'h030;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RSSR_RST_SEC_STATUS = 8'h00;
  localparam logic [6:0] RSSR_RST_CHANNEL = 7'h0B;
  localparam logic [3:0] RSSR_RST_XTAL_TRIM = 4'hF;
  localparam logic [7:0] RSSR_RST_TX_POWER = 8'h06;

  // ----------------------------------------------------------------
  // Field positions in the security status register, and setting widths
  // ----------------------------------------------------------------
  localparam int RSSR_BIT_AUTH_HIGH = 3;
  localparam int RSSR_BIT_AUTH_LOW = 2;
  localparam int RSSR_BIT_RUN_HIGH = 1;
  localparam int RSSR_BIT_RUN_LOW = 0;
  localparam int RSSR_CHANNEL_W = 7;
  localparam int RSSR_TRIM_W = 4;

  // ----------------------------------------------------------------
  // Frequency plan
  // ----------------------------------------------------------------
  localparam logic [11:0] RSSR_BASE_MHZ = 12'h95A;
  localparam logic [6:0] RSSR_CHANNEL_MAX = 7'h71;

  // Completion report from one queue of the security engine
  typedef struct packed {
    logic running;
    logic done;
    logic is_auth;
    logic auth_pass;
  } rssr_queue_evt_t;

  // Register write or read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } rssr_req_t;

endpackage

// *** hdl/rssr_freq_map.sv ***
`timescale 1ns/1ns
module rssr_freq_map (
  input wire logic [6:0] offset_in,
  output logic [11:0] carrier_mhz_out,
  output logic saturated_out
);

  // ----------------------------------------------------------------
  // Offset to carrier frequency
  // ----------------------------------------------------------------

  always_comb begin
    saturated_out = (offset_in > rssr_pkg::RSSR_CHANNEL_MAX);
    if (saturated_out) begin
      carrier_mhz_out = rssr_pkg::RSSR_BASE_MHZ + {5'h00, rssr_pkg::RSSR_CHANNEL_MAX};
    end else begin
      carrier_mhz_out = rssr_pkg::RSSR_BASE_MHZ + {5'h00, offset_in};
    end
  end

endmodule // rssr_freq_map

// *** hdl/rssr_regs.sv ***
`timescale 1ns/1ns
// Function
// - high auth bit updates on completion only
// - low auth bit updates on completion only
// - auth bit 0 fail, 1 pass
// - bit 1 shows high queue running
// - bit 0 shows low queue running
// - seven-bit offset, reset 0x0B, 2394 base
// - offsets 114-127 saturate at top
// - four-bit trim, resets to all ones
module rssr_regs (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire rssr_pkg::rssr_req_t req_in,
  input wire rssr_pkg::rssr_queue_evt_t high_evt_in,
  input wire rssr_pkg::rssr_queue_evt_t low_evt_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic addr_hit_out,
  output logic [6:0] channel_offset_out,
  output logic [11:0] carrier_mhz_out,
  output logic channel_saturated_out,
  output logic [3:0] crystal_trim_code_out,
  output logic [7:0] tx_power_code_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic auth_result_high_prio;
  logic auth_result_low_prio;
  logic high_prio_instr_running;
  logic low_prio_instr_running;
  logic [6:0] channel;
  logic [3:0] trim;
  logic [7:0] power;
  logic [7:0] rdata;
  logic rvalid;
  logic next_auth_result_high_prio;
  logic next_auth_result_low_prio;
  logic next_high_prio_instr_running;
  logic next_low_prio_instr_running;
  logic [6:0] next_channel;
  logic [3:0] next_trim;
  logic [7:0] next_power;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [7:0] status_word;

  // Auth result update: only on authenticating completions
  function automatic logic auth_next(input logic cur, input rssr_pkg::rssr_queue_evt_t evt);
    auth_next = (evt.done && evt.is_auth) ? evt.auth_pass : cur;
  endfunction

  // ----------------------------------------------------------------
  // Security status tracking
  // ----------------------------------------------------------------

  // Host writes never reach these bits, so status cannot be corrupted
  always_comb begin
    next_auth_result_high_prio = auth_next(auth_result_high_prio, high_evt_in);
    next_auth_result_low_prio = auth_next(auth_result_low_prio, low_evt_in);
    next_high_prio_instr_running = high_evt_in.running;
    next_low_prio_instr_running = low_evt_in.running;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      auth_result_high_prio <= rssr_pkg::RSSR_RST_SEC_STATUS[rssr_pkg::RSSR_BIT_AUTH_HIGH];
      auth_result_low_prio <= rssr_pkg::RSSR_RST_SEC_STATUS[rssr_pkg::RSSR_BIT_AUTH_LOW];
      high_prio_instr_running <= rssr_pkg::RSSR_RST_SEC_STATUS[rssr_pkg::RSSR_BIT_RUN_HIGH];
      low_prio_instr_running <= rssr_pkg::RSSR_RST_SEC_STATUS[rssr_pkg::RSSR_BIT_RUN_LOW];
    end else begin
      auth_result_high_prio <= next_auth_result_high_prio;
      auth_result_low_prio <= next_auth_result_low_prio;
      high_prio_instr_running <= next_high_prio_instr_running;
      low_prio_instr_running <= next_low_prio_instr_running;
    end
  end

  // pass reads 1, fail reads 0
  always_comb begin
    status_word = 8'h00;
    status_word[rssr_pkg::RSSR_BIT_AUTH_HIGH] = auth_result_high_prio;
    status_word[rssr_pkg::RSSR_BIT_AUTH_LOW] = auth_result_low_prio;
    status_word[rssr_pkg::RSSR_BIT_RUN_HIGH] = high_prio_instr_running;
    status_word[rssr_pkg::RSSR_BIT_RUN_LOW] = low_prio_instr_running;
  end

  // ----------------------------------------------------------------
  // Writable settings
  // ----------------------------------------------------------------

  always_comb begin
    next_channel = channel;
    next_trim = trim;
    next_power = power;
    if (req_in.wr) begin
      unique case (req_in.addr)
        rssr_pkg::RSSR_OFS_CHANNEL: begin
          next_channel = req_in.wdata[6:0];
        end
        rssr_pkg::RSSR_OFS_XTAL_TRIM: begin
          next_trim = req_in.wdata[3:0];
        end
        rssr_pkg::RSSR_OFS_TX_POWER: begin
          next_power = req_in.wdata;
        end
        default: begin
          next_channel = channel;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      channel <= rssr_pkg::RSSR_RST_CHANNEL;
      trim <= rssr_pkg::RSSR_RST_XTAL_TRIM;
      power <= rssr_pkg::RSSR_RST_TX_POWER;
    end else begin
      channel <= next_channel;
      trim <= next_trim;
      power <= next_power;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unmapped and reserved bits read zero
  always_comb begin
    next_rvalid = req_in.rd;
    next_rdata = 8'h00;
    if (req_in.rd) begin
      unique case (req_in.addr)
        rssr_pkg::RSSR_OFS_SEC_STATUS: begin
          next_rdata = status_word;
        end
        rssr_pkg::RSSR_OFS_CHANNEL: begin
          next_rdata = {1'b0, channel};
        end
        rssr_pkg::RSSR_OFS_XTAL_TRIM: begin
          next_rdata = {4'h0, trim};
        end
        rssr_pkg::RSSR_OFS_TX_POWER: begin
          next_rdata = power;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Combinational decode flag for the link front end
  assign addr_hit_out = (req_in.addr == rssr_pkg::RSSR_OFS_SEC_STATUS) ||
                        (req_in.addr == rssr_pkg::RSSR_OFS_CHANNEL) ||
                        (req_in.addr == rssr_pkg::RSSR_OFS_XTAL_TRIM) ||
                        (req_in.addr == rssr_pkg::RSSR_OFS_TX_POWER);
  assign rdata_out = rdata;
  assign rvalid_out = rvalid;
  assign channel_offset_out = channel;
  assign crystal_trim_code_out = trim;
  assign tx_power_code_out = power;

  // ----------------------------------------------------------------
  // Carrier frequency
  // ----------------------------------------------------------------

  rssr_freq_map u_freq_map (
    .offset_in(channel),
    .carrier_mhz_out(carrier_mhz_out),
    .saturated_out(channel_saturated_out)
  );

endmodule // rssr_regs

// *** tb/rssr_regs_properties.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Port checks for the status and tuning bank
// ----------------------------------------
module rssr_regs_properties (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire rssr_pkg::rssr_req_t req_in,
  input wire rssr_pkg::rssr_queue_evt_t high_evt_in,
  input wire rssr_pkg::rssr_queue_evt_t low_evt_in,
  input wire logic [7:0] rdata_out,
  input wire logic [6:0] channel_offset_out,
  input wire logic [11:0] carrier_mhz_out,
  input wire logic channel_saturated_out
);
  logic [1:0] auth_seen;
  logic [1:0] next_auth_seen;
  logic st_rd;
  logic ch_wr;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  // Status read and channel write decodes
  assign st_rd = req_in.rd && req_in.addr == rssr_pkg::RSSR_OFS_SEC_STATUS;
  assign ch_wr = req_in.wr && req_in.addr == rssr_pkg::RSSR_OFS_CHANNEL;
  // Last verdict per queue; plain done must not disturb it
  always_comb begin
    next_auth_seen = auth_seen;
    if (high_evt_in.done && high_evt_in.is_auth) next_auth_seen[1] = high_evt_in.auth_pass;
    if (low_evt_in.done && low_evt_in.is_auth) next_auth_seen[0] = low_evt_in.auth_pass;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) auth_seen <= 2'h0;
    else auth_seen <= next_auth_seen;
  end
  auth_high_a: assert property (st_rd |=> rdata_out[3] == $past(auth_seen[1]))
    else $error("high auth bit wrong");
  auth_low_a: assert property (st_rd |=> rdata_out[2] == $past(auth_seen[0]))
    else $error("low auth bit wrong");
  run_high_a: assert property (st_rd |=> rdata_out[1] == $past(high_evt_in.running, 2))
    else $error("high running bit wrong");
  run_low_a: assert property (st_rd |=> rdata_out[0] == $past(low_evt_in.running, 2))
    else $error("low running bit wrong");
  status_reserved_a: assert property (st_rd |=> rdata_out[7:4] == 4'h0)
    else $error("status reserved bits set");
  chan_write_a: assert property (ch_wr |=> channel_offset_out == $past(req_in.wdata[6:0]))
    else $error("channel write lost");
  chan_hold_a: assert property (!ch_wr |=> $stable(channel_offset_out))
    else $error("channel changed unasked");
  carrier_map_a: assert property (channel_offset_out <= 7'h71 |->
    carrier_mhz_out == 12'h95A + 12'(channel_offset_out) && !channel_saturated_out) else $error("carrier wrong");
  carrier_sat_a: assert property (channel_offset_out > 7'h71 |->
    carrier_mhz_out == 12'h9CB && channel_saturated_out) else $error("carrier not clamped");
  // Main scenarios reached
  cover property (high_evt_in.done && high_evt_in.is_auth && !high_evt_in.auth_pass);
  cover property (channel_saturated_out);
  cover property (st_rd && low_evt_in.running);
endmodule // rssr_regs_properties

// *** tb/rssr_host_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Host side request driver
// ----------------------------------------
module rssr_host_model (
  input wire logic clk_sys_in,
  output rssr_pkg::rssr_req_t req_out,
  input wire logic [7:0] rdata_in,
  input wire logic hit_in
);
  logic [7:0] last_rd;
  logic last_hit;
  // Idle from time zero
  initial req_out = '0;
  function automatic logic [7:0] chan_offset(input int ch);
    return 8'(11 + 5 * (ch - 11));
  endfunction
  // one write per cycle, held to the edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in);
    req_out = '0;
  endtask
  // Read data stands one cycle, so take it at the next low phase
  task automatic rd(input logic [11:0] a);
    @(negedge clk_sys_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    // Decode flag is combinational, so catch it while the request stands
    @(posedge clk_sys_in);
    last_hit = hit_in;
    @(negedge clk_sys_in);
    req_out = '0;
    last_rd = rdata_in;
  endtask
endmodule // rssr_host_model

// *** tb/rssr_regs_tb.sv ***
`timescale 1ns/1ns
module rssr_regs_tb;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  rssr_pkg::rssr_req_t req;
  rssr_pkg::rssr_queue_evt_t hi = '0;
  rssr_pkg::rssr_queue_evt_t lo = '0;
  logic [7:0] rdata;
  logic [6:0] chan;
  logic [11:0] mhz;
  logic sat;
  logic rv;
  logic hit;
  logic [3:0] trim;
  logic [7:0] pwr;
  int miscompares = 0;
  int checked = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  rssr_host_model u_rssr_host_model (.clk_sys_in, .req_out(req), .rdata_in(rdata), .hit_in(hit));
  rssr_regs u_rssr_regs (.clk_sys_in, .reset_n_in, .req_in(req), .high_evt_in(hi), .low_evt_in(lo),
    .rdata_out(rdata), .rvalid_out(rv), .addr_hit_out(hit), .channel_offset_out(chan), .carrier_mhz_out(mhz),
    .channel_saturated_out(sat), .crystal_trim_code_out(trim), .tx_power_code_out(pwr));
  task automatic check(input string n, input logic [11:0] s, input logic [11:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    u_rssr_host_model.rd(a);
    check("read data", {4'h0, u_rssr_host_model.last_rd}, {4'h0, e});
    check("read valid", {11'h000, rv}, 12'h001);
    check("address hit", {11'h000, u_rssr_host_model.last_hit},
      {11'h000, a == 12'h02C || a == 12'h02E || a == 12'h02F || a == 12'h030});
  endtask
  // One completion pulse; the queue stops running with it
  task automatic fin(input logic h, input logic au, input logic p);
    @(negedge clk_sys_in);
    if (h) hi = '{1'b0, 1'b1, au, p};
    else lo = '{1'b0, 1'b1, au, p};
    @(negedge clk_sys_in);
    hi.done = 1'b0;
    lo.done = 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run is near a hundred cycles
  initial begin
    #4000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (20) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    check("read valid", {11'h000, rv}, 12'h000);
    check("trim", {8'h00, trim}, 12'h00F);
    check("power", {4'h0, pwr}, 12'h006);
    rchk(12'h02C, 8'h00);
    rchk(12'h02E, 8'h0B);
    rchk(12'h02F, 8'h0F);
    rchk(12'h030, 8'h06);
    check("carrier", mhz, 12'h965);
    $display("test reset values done");
    u_rssr_host_model.wr(12'h02E, u_rssr_host_model.chan_offset(26));
    check("carrier", mhz, 12'h9B0);
    u_rssr_host_model.wr(12'h02E, 8'hF2);
    rchk(12'h02E, 8'h72);
    check("carrier", mhz, 12'h9CB);
    check("clamp", {11'h000, sat}, 12'h001);
    u_rssr_host_model.wr(12'h02E, 8'h71);
    check("clamp", {11'h000, sat}, 12'h000);
    u_rssr_host_model.wr(12'h02F, 8'hA5);
    check("trim", {8'h00, trim}, 12'h005);
    rchk(12'h02F, 8'h05);
    u_rssr_host_model.wr(12'h030, 8'h5A);
    check("power", {4'h0, pwr}, 12'h05A);
    rchk(12'h030, 8'h5A);
    u_rssr_host_model.wr(12'h02C, 8'hFF);
    rchk(12'h02C, 8'h00);
    rchk(12'h031, 8'h00);
    $display("test settings done");
    hi.running = 1'b1;
    rchk(12'h02C, 8'h02);
    lo.running = 1'b1;
    rchk(12'h02C, 8'h03);
    fin(1'b1, 1'b1, 1'b0);
    rchk(12'h02C, 8'h01);
    fin(1'b1, 1'b0, 1'b1);
    rchk(12'h02C, 8'h01);
    fin(1'b1, 1'b1, 1'b1);
    rchk(12'h02C, 8'h09);
    fin(1'b0, 1'b1, 1'b1);
    rchk(12'h02C, 8'h0C);
    fin(1'b0, 1'b0, 1'b0);
    rchk(12'h02C, 8'h0C);
    fin(1'b0, 1'b1, 1'b0);
    rchk(12'h02C, 8'h08);
    $display("test status done");
    // Mid-run reset must restore every setting and clear the status
    @(negedge clk_sys_in);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    check("channel", {5'h00, chan}, 12'h00B);
    check("trim", {8'h00, trim}, 12'h00F);
    check("power", {4'h0, pwr}, 12'h006);
    rchk(12'h02C, 8'h00);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // rssr_regs_tb
bind rssr_regs rssr_regs_properties u_rssr_regs_properties (.clk_sys_in, .reset_n_in, .req_in, .high_evt_in,
  .low_evt_in, .rdata_out, .channel_offset_out, .carrier_mhz_out, .channel_saturated_out);
